// ==== hw/ctd_detector.sv ====
// Purpose: Race decision, correction pulses, run counter and switch output.
// Assumes: Comparator levels are asynchronous to core_clk; mode is static.
// Notes:   The sampling tick is made from core_clk by a dithered divider.

module ctd_detector #(
  parameter int RUN_THRESHOLD = ctd_pkg::RUN_THRESHOLD,
  parameter int CNT_W         = 32,
  parameter int CAP_NF10_W    = 12
) (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  // Comparators, active low when below reference
  input  wire logic                  refCompN,
  input  wire logic                  senseCompN,
  // Configuration
  input  wire logic [1:0]            modeSel,
  input  wire logic [CAP_NF10_W-1:0] modeCapNf10,
  // Timing circuit charge switch, shared by both circuits
  output logic                       chargeSwitch,
  // Sensitivity capacitor pin drive
  output logic                       up_correction_pulse,
  output logic                       down_correction_pulse,
  // Switch output
  output logic                       switchOut,
  output logic                       switchOutEn
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rstMeta;
  logic rstSyncN;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta  <= 1'b0;
      rstSyncN <= 1'b0;
    end else begin
      rstMeta  <= 1'b1;
      rstSyncN <= rstMeta;
    end
  end

  // ****************************************************************
  // Dithered oscillator
  // ****************************************************************
  logic [15:0] lfsr;
  logic [15:0] halfCnt;
  logic        phaseTick;

  function automatic logic [15:0] halfLoad(input logic [15:0] rnd);
    logic [15:0] base;
    base = 16'(ctd_pkg::OSC_HALF_CYC - ctd_pkg::SPREAD_CYC);
    halfLoad = base + 16'(rnd % 16'(2 * ctd_pkg::SPREAD_CYC + 1));
  endfunction : halfLoad

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      lfsr <= 16'(ctd_pkg::LFSR_SEED);
    end else if (phaseTick) begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
  end

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      halfCnt <= 16'(ctd_pkg::OSC_HALF_CYC - 1);
    end else if (phaseTick) begin
      halfCnt <= halfLoad(lfsr) - 16'h0001;
    end else begin
      halfCnt <= halfCnt - 16'h0001;
    end
  end

  assign phaseTick = (halfCnt == 16'h0000);

  // Charge phase is one oscillator half period, discharge the next; the sample
  // tick falls at the end of each discharge, so fs equals the oscillator.
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      chargeSwitch <= 1'b1;
    end else if (phaseTick) begin
      chargeSwitch <= !chargeSwitch;
    end
  end

  logic sampleTick;
  assign sampleTick = phaseTick && !chargeSwitch;

  // ****************************************************************
  // Comparator synchronisers and race
  // ****************************************************************
  logic refMeta;
  logic refSync;
  logic senseMeta;
  logic senseSync;

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      refMeta   <= 1'b1;
      refSync   <= 1'b1;
      senseMeta <= 1'b1;
      senseSync <= 1'b1;
    end else begin
      refMeta   <= refCompN;
      refSync   <= refMeta;
      senseMeta <= senseCompN;
      senseSync <= senseMeta;
    end
  end

  // First low-going comparator in the discharge phase wins; a tie is given
  // to the reference so that the loop keeps a slight upward bias.
  logic decided;
  logic refWon;

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      decided <= 1'b0;
      refWon  <= 1'b0;
    end else if (chargeSwitch || sampleTick) begin
      decided <= 1'b0;
    end else if (!decided && (!refSync || !senseSync)) begin
      decided <= 1'b1;
      refWon  <= !refSync;
    end
  end

  // A cycle with no comparator fall counts as a sensor win: the plate is
  // taken as faster than the reference.
  logic upEvent;
  logic downEvent;
  assign upEvent   = sampleTick && decided && refWon;
  assign downEvent = sampleTick && !(decided && refWon);

  // ****************************************************************
  // Correction pulses
  // ****************************************************************
  logic [7:0] corrCnt;

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      corrCnt <= 8'h00;
    end else if (upEvent || downEvent) begin
      corrCnt <= 8'(ctd_pkg::CORR_CYC);
    end else if (corrCnt != 8'h00) begin
      corrCnt <= corrCnt - 8'h01;
    end
  end

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      up_correction_pulse   <= 1'b0;
      down_correction_pulse <= 1'b0;
    end else if (upEvent || downEvent) begin
      up_correction_pulse   <= upEvent;
      down_correction_pulse <= downEvent;
    end else if (corrCnt == 8'h01) begin
      up_correction_pulse   <= 1'b0;
      down_correction_pulse <= 1'b0;
    end
  end

  // ****************************************************************
  // Run counter and event detection
  // ****************************************************************
  logic [7:0] runCnt;
  logic       lastUp;
  logic       eventActive;

  // Alternating pulses keep the count at one, so a balanced loop never
  // reaches the threshold.
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      runCnt <= 8'h00;
      lastUp <= 1'b0;
    end else if (sampleTick) begin
      lastUp <= upEvent;
      if (upEvent != lastUp) begin
        runCnt <= 8'h01;
      end else if (runCnt != 8'hFF) begin
        runCnt <= runCnt + 8'h01;
      end
    end
  end

  // Up runs mean the plate capacitance rose: the event is present.
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      eventActive <= 1'b0;
    end else if (sampleTick && runCnt >= 8'(RUN_THRESHOLD - 1)
                 && upEvent == lastUp) begin
      eventActive <= upEvent;
    end
  end

  logic eventPrev;
  logic eventRise;

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      eventPrev <= 1'b0;
    end else begin
      eventPrev <= eventActive;
    end
  end

  assign eventRise = eventActive && !eventPrev;

  // ****************************************************************
  // Output modes
  // ****************************************************************
  logic [CNT_W-1:0] pulseLoad;
  logic             pulseBusy;
  logic             pulseStart;

  assign pulseLoad  = CNT_W'(modeCapNf10) *
    CNT_W'(ctd_pkg::PULSE_US_PER_NF10 / 10 * 1000 / ctd_pkg::CLK_PERIOD_NS
           / 10);
  assign pulseStart = eventRise && !pulseBusy
                      && modeSel == ctd_pkg::CTD_MODE_PULSE;

  ctd_pulse_timer #(
    .CNT_W      (CNT_W)
  ) u_pulse (
    .core_clk   (core_clk),
    .rstSyncN   (rstSyncN),
    .start      (pulseStart),
    .loadCycles (pulseLoad),
    .busy       (pulseBusy)
  );

  logic toggleState;

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      toggleState <= 1'b0;
    end else if (eventRise && modeSel == ctd_pkg::CTD_MODE_TOGGLE) begin
      toggleState <= !toggleState;
    end
  end

  logic next_switch;

  always_comb begin
    case (modeSel)
      ctd_pkg::CTD_MODE_PUSH:   next_switch = eventActive;
      ctd_pkg::CTD_MODE_TOGGLE: next_switch = toggleState;
      ctd_pkg::CTD_MODE_PULSE:  next_switch = pulseBusy;
      default:                  next_switch = eventActive;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      switchOut   <= 1'b0;
      switchOutEn <= 1'b0;
    end else begin
      switchOut   <= next_switch;
      switchOutEn <= next_switch;
    end
  end

endmodule : ctd_detector

// ==== hw/ctd_pkg.sv ====
// Purpose: Shared constants for the capacitive touch event detector.
// Assumes: One clock, core_clk at 100 MHz; mode pin gives two select bits.
// Notes:   Times are given in their own unit with derived cycle counts.
package ctd_pkg;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Output modes
  // ****************************************************************
  typedef enum logic [1:0] {
    CTD_MODE_PUSH   = 2'h0,
    CTD_MODE_TOGGLE = 2'h1,
    CTD_MODE_PULSE  = 2'h2
  } ctd_mode_t;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS       = 10;
  // Oscillator half period before modulation, in nanoseconds.
  localparam int OSC_HALF_NS         = 500;
  localparam int OSC_HALF_CYC        = OSC_HALF_NS / CLK_PERIOD_NS;
  // Spread in percent of the half period.
  localparam int SPREAD_PCT          = 4;
  localparam int SPREAD_CYC          =
    (OSC_HALF_CYC * SPREAD_PCT + 99) / 100;
  // Correction pulse width, in nanoseconds.
  localparam int CORR_NS             = 100;
  localparam int CORR_CYC            =
    (CORR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Pulse mode duration per nanofarad, in tenths of a microsecond.
  localparam int PULSE_US_PER_NF10   = 25000;
  localparam int LFSR_SEED           = 16'hACE1;
  localparam int RUN_THRESHOLD       = 8;

endpackage : ctd_pkg

// ==== hw/ctd_pulse_timer.sv ====
// Purpose: Down counter that holds the pulse-mode output active.
// Assumes: start is a one-cycle pulse; load value already in cycles.
// Notes:   A start while busy is ignored by the caller, not here.
module ctd_pulse_timer #(
  parameter int CNT_W = 32
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rstSyncN,
  // Control
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] loadCycles,
  // Status
  output logic                  busy
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [CNT_W-1:0] remain;

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      remain <= '0;
    end else if (start) begin
      remain <= loadCycles;
    end else if (remain != '0) begin
      remain <= remain - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      busy <= 1'b0;
    end else begin
      busy <= start || (remain > {{(CNT_W-1){1'b0}}, 1'b1});
    end
  end

endmodule : ctd_pulse_timer

// ==== tb/ctd_detector_asserts.sv ====
// Purpose: Port checker for the touch event detector.
// Assumes: Bound to the detector top.
// Notes:   Run counts are rebuilt from the correction pulses.
module ctd_detector_asserts #(
  parameter int RUN_THRESHOLD = 8,
  parameter int CNT_W         = 32,
  parameter int CAP_NF10_W    = 12
) (
  // Inputs and outputs of the detector
  input wire logic                  core_clk,
  input wire logic                  nrst,
  input wire logic                  refCompN,
  input wire logic                  senseCompN,
  input wire logic [1:0]            modeSel,
  input wire logic [CAP_NF10_W-1:0] modeCapNf10,
  input wire logic                  chargeSwitch,
  input wire logic                  up_correction_pulse,
  input wire logic                  down_correction_pulse,
  input wire logic                  switchOut,
  input wire logic                  switchOutEn
);
  timeunit 1ns;
  timeprecision 1ps;
  int   corrLen, outLen, phLen, runUp, runDn, nPulse;
  logic prevCs, seen, chg, up, dn;
  assign up  = up_correction_pulse;
  assign dn  = down_correction_pulse;
  assign chg = chargeSwitch != prevCs;
  assign nPulse = int'(modeCapNf10) * 25000;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      corrLen <= 0;
      outLen  <= 0;
      phLen   <= 0;
      runUp   <= 0;
      runDn   <= 0;
      prevCs  <= 1'b1;
      seen    <= 1'b0;
    end else begin
      corrLen <= (up || dn) ? corrLen + 1 : 0;
      outLen  <= switchOut ? outLen + 1 : 0;
      phLen   <= chg ? 0 : phLen + 1;
      prevCs  <= chargeSwitch;
      seen    <= seen | chg;
      runUp   <= $rose(dn) ? 0 : runUp + int'($rose(up));
      runDn   <= $rose(up) ? 0 : runDn + int'($rose(dn));
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_one_direction: assert property (!(up && dn))
    else $error("up and down pulses together");
  a_pulse_width: assert property ($fell(up) || $fell(dn) |->
    corrLen == ctd_pkg::CORR_CYC) else $error("correction width wrong");
  a_tick_decides: assert property ($rose(chargeSwitch) |->
    ##[0:2] (up || dn)) else $error("no decision at tick");
  a_pulse_at_tick: assert property ($rose(up) || $rose(dn) |->
    ##[0:2] chargeSwitch) else $error("pulse away from tick");
  a_phase_len: assert property (chg && seen |->
    phLen >= 47 && phLen <= 51) else $error("phase length wrong");
  a_enable_match: assert property (switchOutEn == switchOut)
    else $error("enable differs from output");
  a_run_to_on: assert property ($rose(switchOut) |->
    runUp >= RUN_THRESHOLD) else $error("output on without run");
  a_push_off: assert property ($fell(switchOut) && modeSel == 2'h0 |->
    runDn >= RUN_THRESHOLD) else $error("push output off early");
  a_pulse_len: assert property ($fell(switchOut) && modeSel == 2'h2 |->
    outLen >= nPulse - 2 && outLen <= nPulse + 2)
    else $error("pulse length wrong");
  c_push: cover property ($rose(switchOut) && modeSel == 2'h0);
  c_toggle: cover property ($fell(switchOut) && modeSel == 2'h1);
  c_pulse: cover property ($fell(switchOut) && modeSel == 2'h2);
endmodule : ctd_detector_asserts

// ==== tb/ctd_detector_tb.sv ====
// Purpose: Self-checking bench for the touch event detector.
// Assumes: Plate model answers each discharge phase.
// Notes:   Delays change early in a charge phase, so each tick is clean.
module ctd_detector_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk = 1'b0, nrst = 1'b0;
  logic [1:0] modeSel = 2'h0;
  logic [11:0] modeCapNf10 = 12'h001;
  logic [7:0] refDly = 8'hFF, senseDly = 8'hFF;
  logic refCompN, senseCompN, chargeSwitch, upP, dnP, switchOut, outEn;
  int n_errors = 0, n_compared = 0, nUp, nDn, chgAt;
  ctd_detector u_ctd_detector (.core_clk(core_clk), .nrst(nrst),
    .refCompN(refCompN), .senseCompN(senseCompN), .modeSel(modeSel),
    .modeCapNf10(modeCapNf10), .chargeSwitch(chargeSwitch),
    .up_correction_pulse(upP), .down_correction_pulse(dnP),
    .switchOut(switchOut), .switchOutEn(outEn));
  ctd_plate_model u_ctd_plate_model (.core_clk(core_clk),
    .chargeSwitch(chargeSwitch), .refDly(refDly), .senseDly(senseDly),
    .refCompN(refCompN), .senseCompN(senseCompN));
  initial forever #5 core_clk = ~core_clk;
  task automatic step();
    @(posedge core_clk);
    #1;
  endtask : step
  task automatic check(input string what, input logic [31:0] exp, got);
    n_compared++;
    if (exp !== got) begin
      n_errors++;
      $display("CHECK FAILED %s exp %0h got %0h", what, exp, got);
    end
  endtask : check
  task automatic report_and_stop();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic do_reset(input logic [1:0] mode);
    nrst = 1'b0;
    modeSel = mode;
    repeat (16) step();
    check("rst", 32'h10, {chargeSwitch, upP, dnP, switchOut, outEn});
    nrst = 1'b1;
  endtask : do_reset
  // Counts pulses until n are seen, and notes the count at an output change.
  task automatic run_ticks(input int n, input logic [7:0] rd, sd);
    int guard, tail;
    logic pu, pd, po;
    {guard, tail, nUp, nDn, chgAt} = {32'd0, 32'd0, 32'd0, 32'd0, -32'sd1};
    {refDly, senseDly, pu, pd, po} = {rd, sd, upP, dnP, switchOut};
    while (tail < 5) begin
      step();
      guard++;
      if (guard > 200 * n + 300) begin
        n_errors++;
        report_and_stop();
      end
      nUp += int'(upP && !pu);
      nDn += int'(dnP && !pd);
      if (switchOut !== po && chgAt < 0) chgAt = nUp + nDn;
      {pu, pd} = {upP, dnP};
      if (nUp + nDn >= n) tail++;
    end
  endtask : run_ticks
  task automatic push_mode();
    do_reset(2'h0);
    run_ticks(5, 8'd10, 8'd30);
    check("up", 5, nUp);
    run_ticks(2, 8'd30, 8'd10);
    check("down", 2, nDn);
    // The alternation ends on a down, so the next up run starts at one.
    for (int i = 0; i < 6; i++) begin
      run_ticks(1, i[0] ? 8'd30 : 8'd10, i[0] ? 8'd10 : 8'd30);
      check("alt", !i[0], nUp);
    end
    run_ticks(7, 8'd10, 8'd30);
    check("short run", 0, switchOut);
    run_ticks(1, 8'd10, 8'd30);
    check("on at", 1, chgAt);
    run_ticks(8, 8'hFF, 8'hFF);
    check("off at", 8, chgAt);
  endtask : push_mode
  task automatic toggle_mode();
    do_reset(2'h1);
    run_ticks(8, 8'd10, 8'd30);
    check("tog on", 8, chgAt);
    run_ticks(8, 8'd30, 8'd10);
    check("tog hold", -1, chgAt);
    run_ticks(8, 8'd10, 8'd30);
    check("tog off", 8, chgAt);
  endtask : toggle_mode
  task automatic pulse_mode();
    int len;
    do_reset(2'h2);
    run_ticks(8, 8'd10, 8'd30);
    // The output rose two edges before the run above returned.
    len = 2;
    while (switchOut === 1'b1 && len < 30000) begin
      if (len == 3000) {refDly, senseDly} = {8'd30, 8'd10};
      if (len == 6000) {refDly, senseDly} = {8'd10, 8'd30};
      step();
      len++;
    end
    check("pulse len", 1, len >= 24998 && len <= 25002);
    repeat (300) step();
    check("ignored", 0, switchOut);
  endtask : pulse_mode
  // The unused select code must behave as push-button mode.
  task automatic spare_mode();
    do_reset(2'h3);
    run_ticks(8, 8'd10, 8'd30);
    check("spare on", 8, chgAt);
    run_ticks(8, 8'hFF, 8'hFF);
    check("spare off", 8, chgAt);
  endtask : spare_mode
  initial begin
    push_mode();
    toggle_mode();
    pulse_mode();
    spare_mode();
    report_and_stop();
  end
endmodule : ctd_detector_tb

bind ctd_detector ctd_detector_asserts #(.RUN_THRESHOLD(RUN_THRESHOLD),
  .CNT_W(CNT_W), .CAP_NF10_W(CAP_NF10_W)) u_ctd_detector_asserts (
  .core_clk(core_clk), .nrst(nrst), .refCompN(refCompN),
  .senseCompN(senseCompN), .modeSel(modeSel), .modeCapNf10(modeCapNf10),
  .chargeSwitch(chargeSwitch), .up_correction_pulse(up_correction_pulse),
  .down_correction_pulse(down_correction_pulse), .switchOut(switchOut),
  .switchOutEn(switchOutEn));

// ==== tb/ctd_plate_model.sv ====
// Purpose: Sensing plate seen through its two comparators.
// Assumes: Delays count cycles from charge end; 8'hFF never falls.
// Notes:   Both comparators read high while charging.
module ctd_plate_model (
  // Clock and phase
  input  wire logic       core_clk,
  input  wire logic       chargeSwitch,
  // Fall delays
  input  wire logic [7:0] refDly,
  input  wire logic [7:0] senseDly,
  // Comparators
  output logic            refCompN,
  output logic            senseCompN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] age = 8'h00;
  always_ff @(posedge core_clk) begin
    age        <= chargeSwitch ? 8'h00 : age + 8'h01;
    refCompN   <= chargeSwitch || age < refDly || refDly == 8'hFF;
    senseCompN <= chargeSwitch || age < senseDly || senseDly == 8'hFF;
  end
endmodule : ctd_plate_model
